// ---- shared/irq_mask_pkg.sv ----
// Constants for the maskable-interrupt mask register bank.
// Assumes an 8-bit CPU data path with 16-bit byte addresses.
package irq_mask_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NUM_REGS = 4;
    localparam int unsigned NUM_SRC = NUM_REGS * DATA_W;
    // Byte addresses of the four mask registers
    localparam logic [15:0] IRQ_MASK_LOW_A_ADDR = 16'hFFE4;
    localparam logic [15:0] IRQ_MASK_HIGH_A_ADDR = 16'hFFE5;
    localparam logic [15:0] IRQ_MASK_LOW_B_ADDR = 16'hFFE6;
    localparam logic [15:0] IRQ_MASK_HIGH_B_ADDR = 16'hFFE7;
    localparam logic [15:0] IRQ_MASK_BASE_ADDR = 16'hFFE4;
    // Value after reset: every source blocked
    localparam logic [7:0] IRQ_MASK_RESET = 8'hFF;
    // Access sizes on the CPU write port
    localparam logic [1:0] ACC_BIT = 2'h0;
    localparam logic [1:0] ACC_BYTE = 2'h1;
    localparam logic [1:0] ACC_WORD = 2'h2;
endpackage : irq_mask_pkg

// ---- verilog/irq_mask_byte.sv ----
// One 8-bit mask register with bit and byte write; the stored value drives o_q directly, with no read port.
// Assumes writes are decoded by the parent into a per-bit write enable.
`timescale 1ns/1ps
`default_nettype none
module irq_mask_byte
    import irq_mask_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Write side
    input wire logic [7:0] i_bit_we,
    input wire logic [7:0] i_wdata,
    // Stored value
    output logic [7:0] o_q
);
    // Each bit updates only when its own enable is set, so a bit write leaves neighbours alone
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_q <= IRQ_MASK_RESET;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (i_bit_we[i]) begin
                    o_q[i] <= i_wdata[i];
                end
            end
        end
    end
endmodule // irq_mask_byte
`default_nettype wire

// ---- verilog/interrupt_mask_flag_bank.sv ----
// Mask register bank of the maskable interrupt controller, with per-source gating.
// Assumes a single-cycle CPU memory write/read port and request flags held elsewhere.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Each maskable source has one mask bit that decides whether its pending request may be serviced.
// - A mask bit of 0 lets the source be serviced and a 1 blocks it.
// - Each mask byte can be written whole or one bit at a time.
// - Bytes zero and one, and bytes two and three, form 16-bit words written in one access.
// - Reset loads every mask byte with all ones so all sources start blocked.
// - A request flag at 1 means a request is pending and 0 means none.
module interrupt_mask_flag_bank
    import irq_mask_pkg::*;
#(
    parameter int unsigned SRC_COUNT = NUM_SRC
)(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // CPU memory port
    input wire logic [15:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [1:0] i_size,
    input wire logic [2:0] i_bit_sel,
    input wire logic [15:0] i_wdata,
    output logic [15:0] o_rdata,
    output logic o_hit,
    // Request flags from the flag registers
    input wire logic [31:0] i_req_flags,
    // Masking results
    output logic [31:0] o_service_req,
    output logic [31:0] o_mask
);
    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    // The gating and read paths are wired for exactly four bytes of eight sources each,
    // so any other source count is refused here rather than silently truncated
    if (SRC_COUNT != NUM_SRC) begin : g_bad_src_count
        $error("SRC_COUNT must equal four mask bytes of eight bits");
    end
    if (DATA_W != 8 || NUM_REGS != 4) begin : g_bad_layout
        $error("mask bank expects four registers of eight bits");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    function automatic logic [3:0] byte_sel(input logic [15:0] a, input logic [1:0] sz);
        logic [3:0] s;
        s = 4'h0;
        if (a[15:2] == IRQ_MASK_BASE_ADDR[15:2]) begin
            if (sz == ACC_WORD) begin
                // Word access must be even; selects a pair of bytes
                if (!a[0]) begin
                    s = a[1] ? 4'hC : 4'h3;
                end
            end else begin
                s = 4'h1 << a[1:0];
            end
        end
        return s;
    endfunction

    logic [3:0] wsel;
    logic [3:0] rsel;
    logic [7:0] bit_mask;
    logic [31:0] q;
    assign wsel = i_wr ? byte_sel(i_addr, i_size) : 4'h0;
    assign rsel = byte_sel(i_addr, i_size);
    assign bit_mask = (i_size == ACC_BIT) ? (8'h01 << i_bit_sel) : 8'hFF;

    ////////////////////////////////////////////////////////////////////////////
    // Four mask bytes; high byte of a word lands in the odd register
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_byte
        logic [7:0] wd;
        assign wd = (i_size == ACC_WORD && (g % 2) == 1) ? i_wdata[15:8] :
                    (i_size == ACC_BIT) ? {8{i_wdata[0]}} : i_wdata[7:0];
        irq_mask_byte u_byte (
            .i_clk(i_clk),
            .i_resetn(i_resetn),
            .i_bit_we(wsel[g] ? bit_mask : 8'h00),
            .i_wdata(wd),
            .o_q(q[g*8 +: 8])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path; reserved positions read back as stored, software keeps them at one
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_rdata <= 16'h0000;
            o_hit <= 1'b0;
        end else begin
            o_hit <= (i_rd || i_wr) && (rsel != 4'h0);
            if (i_rd) begin
                unique case (rsel)
                    4'h1: o_rdata <= {8'h00, q[7:0]};
                    4'h2: o_rdata <= {8'h00, q[15:8]};
                    4'h4: o_rdata <= {8'h00, q[23:16]};
                    4'h8: o_rdata <= {8'h00, q[31:24]};
                    4'h3: o_rdata <= q[15:0];
                    4'hC: o_rdata <= q[31:16];
                    default: o_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // Gating: flag stays with the source; only the service request is held off
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_service_req <= 32'h0000_0000;
            o_mask <= 32'hFFFF_FFFF;
        end else begin
            o_service_req <= i_req_flags & ~q;
            o_mask <= q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // All properties sample on the rising edge of i_clk. Apart from the reset checks they stand down
    // while i_resetn is low: the bytes are being forced then, and a half-finished attempt would compare
    // against values that reset has already overwritten.

    // Building blocks for the multi-step checks
    // A word write to the first pair of mask bytes
    sequence s_word_write_a;
        i_wr && (i_size == ACC_WORD) && (i_addr == IRQ_MASK_LOW_A_ADDR);
    endsequence

    // A word write to the second pair of mask bytes
    sequence s_word_write_b;
        i_wr && (i_size == ACC_WORD) && (i_addr == IRQ_MASK_LOW_B_ADDR);
    endsequence

    // A byte write to the last mask byte
    sequence s_byte_write_high_b;
        i_wr && (i_size == ACC_BYTE) && (i_addr == IRQ_MASK_HIGH_B_ADDR);
    endsequence

    // A cycle with no write, so the stored value cannot move
    sequence s_quiet_port;
        !i_wr;
    endsequence

    // A single-bit write into the first mask byte
    sequence s_bit_write_a;
        i_wr && (i_size == ACC_BIT) && (i_addr == IRQ_MASK_LOW_A_ADDR);
    endsequence

    // A byte read of the second mask byte
    sequence s_byte_read_high_a;
        i_rd && (i_size == ACC_BYTE) && (i_addr == IRQ_MASK_HIGH_A_ADDR);
    endsequence

    // Reset blocks every source at the outputs
    a_reset_blocks: assert property (@(posedge i_clk)
        !i_resetn |=> (o_mask == 32'hFFFF_FFFF) && (o_service_req == 32'h0000_0000))
        else $error("reset did not block all sources");

    // Reset loads the stored bytes themselves and quiets the read side;
    // a stale read word after reset would look like a live mask value to software
    a_reset_stores: assert property (@(posedge i_clk)
        !i_resetn |=> (q == {NUM_REGS{IRQ_MASK_RESET}}) && (o_rdata == 16'h0000) && !o_hit)
        else $error("reset did not load the mask bytes");

    // Service follows the flags of one cycle earlier, held off by the mask shown now;
    // checked against o_mask rather than the internal bytes so a broken output copy shows up too
    a_mask_gates: assert property (@(posedge i_clk) disable iff (!i_resetn)
        1'b1 |=> o_service_req == ($past(i_req_flags) & ~o_mask))
        else $error("service request not gated by mask");

    // A source whose mask bit is one never shows a service request
    a_blocked_quiet: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (o_service_req & o_mask) == 32'h0000_0000)
        else $error("masked source asked for service");

    // A word write to the second pair stores both bytes at once, low data in the even byte
    a_word_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_word_write_b |=> q[31:16] == $past(i_wdata))
        else $error("word write missed a byte");

    // A word write to the first pair reaches o_mask two edges later when nothing overwrites it
    a_word_shown: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_word_write_a ##1 s_quiet_port |=> o_mask[15:0] == $past(i_wdata, 2))
        else $error("word write not shown in the mask");

    // A byte write reaches o_mask two edges later when nothing overwrites it
    a_byte_shown: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_byte_write_high_b ##1 s_quiet_port |=> o_mask[31:24] == $past(i_wdata[7:0], 2))
        else $error("byte write not shown in the mask");

    // A bit write leaves the other seven bits of its byte alone
    a_bit_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_bit_write_a |=>
        (q[7:0] & ~(8'h01 << $past(i_bit_sel))) == ($past(q[7:0]) & ~(8'h01 << $past(i_bit_sel))))
        else $error("bit write disturbed neighbours");

    // The selected bit takes data bit zero
    a_bit_lands: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_bit_write_a |=> q[$past(i_bit_sel)] == $past(i_wdata[0]))
        else $error("bit write did not land");

    // A write that decodes to no mask byte, unmapped or an odd word address, changes nothing and gives no hit
    a_refused_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_wr && (rsel == 4'h0)) |=> (q == $past(q)) && !o_hit)
        else $error("refused write changed a mask byte");

    // A byte read returns the byte in the low half with the high half clear
    a_byte_read: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_byte_read_high_a |=> o_rdata == {8'h00, $past(q[15:8])})
        else $error("byte read returned the wrong byte");

    // A word read of the second pair returns both bytes, even byte in the low half
    a_word_read: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_rd && (i_size == ACC_WORD) && (i_addr == IRQ_MASK_LOW_B_ADDR)) |=> o_rdata == $past(q[31:16]))
        else $error("word read returned the wrong pair");
endmodule // interrupt_mask_flag_bank
`default_nettype wire

// ---- tb/interrupt_mask_flag_bank_test.sv ----
// Self-checking bench for the interrupt mask register bank.
// Assumes the single-cycle CPU port and the one-cycle read and hit timing of the bank.
`timescale 1ns/1ps
`default_nettype none
module interrupt_mask_flag_bank_test;
    import irq_mask_pkg::*;
    logic i_clk, i_resetn, i_wr, i_rd, o_hit;
    logic [15:0] i_addr, i_wdata, o_rdata;
    logic [1:0] i_size;
    logic [2:0] i_bit_sel;
    logic [31:0] i_req_flags, o_service_req, o_mask;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    interrupt_mask_flag_bank uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wr(i_wr),
        .i_rd(i_rd), .i_size(i_size), .i_bit_sel(i_bit_sel), .i_wdata(i_wdata), .o_rdata(o_rdata),
        .o_hit(o_hit), .i_req_flags(i_req_flags), .o_service_req(o_service_req), .o_mask(o_mask));
    ////////////////////////////////////////
    // Clock, 8 ns period
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    // Hang guard, far above the roughly 70 cycles the tests need
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errors = errors + 1;
            conclude();
        end
    end
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One access; strobes drop at the next falling edge, where hit and read data are valid
    task automatic acc(input logic wr, input logic [15:0] a, input logic [1:0] sz, input logic [2:0] b,
                       input logic [15:0] d);
        @(negedge i_clk);
        i_wr = wr; i_rd = ~wr; i_addr = a; i_size = sz; i_bit_sel = b; i_wdata = d;
        @(negedge i_clk);
        i_wr = 1'b0; i_rd = 1'b0;
    endtask
    // Mask and service outputs lag a write by two edges
    task automatic outs(input logic [31:0] m);
        repeat (2) @(negedge i_clk);
        chk("mask", o_mask, m);
        chk("service", o_service_req, i_req_flags & ~m);
    endtask
    ////////////////////////////////////////
    // Main sequence
    initial begin
        i_resetn = 1'b0; i_wr = 1'b0; i_rd = 1'b0; i_addr = 16'h0000; i_size = ACC_BYTE;
        i_bit_sel = 3'h0; i_wdata = 16'h0000; i_req_flags = 32'hFFFFFFFF;
        repeat (4) @(negedge i_clk);
        i_resetn = 1'b1;
        outs(32'hFFFFFFFF);
        for (int n = 0; n < 4; n++) begin
            acc(1'b0, IRQ_MASK_BASE_ADDR + 16'(n), ACC_BYTE, 3'h0, 16'h0000);
            chk("reset read", {16'h0000, o_rdata}, 32'h000000FF);
            acc(1'b1, IRQ_MASK_BASE_ADDR + 16'(n), ACC_BYTE, 3'h0, 16'(8'h11 * n + 8'h0F));
            chk("write hit", 32'(o_hit), 32'h1);
        end
        outs(32'h4231200F);
        acc(1'b0, IRQ_MASK_LOW_B_ADDR, ACC_BYTE, 3'h0, 16'h0000);
        chk("byte read", {16'h0000, o_rdata}, 32'h00000031);
        // Requests still arrive while masked; only servicing is gated
        i_req_flags = 32'h0F0F0F0F;
        outs(32'h4231200F);
        acc(1'b1, IRQ_MASK_LOW_A_ADDR, ACC_BIT, 3'h7, 16'h0001);
        acc(1'b1, IRQ_MASK_HIGH_B_ADDR, ACC_BIT, 3'h1, 16'h0000);
        outs(32'h4031208F);
        acc(1'b1, IRQ_MASK_LOW_B_ADDR, ACC_WORD, 3'h0, 16'hC3A5);
        acc(1'b1, IRQ_MASK_LOW_A_ADDR, ACC_WORD, 3'h0, 16'h7E81);
        outs(32'hC3A57E81);
        acc(1'b0, IRQ_MASK_LOW_B_ADDR, ACC_WORD, 3'h0, 16'h0000);
        chk("word read", {16'h0000, o_rdata}, 32'h0000C3A5);
        // Refused places: unmapped byte and odd word address
        acc(1'b1, 16'hFFE8, ACC_BYTE, 3'h0, 16'h0000);
        chk("unmapped hit", 32'(o_hit), 32'h0);
        acc(1'b1, IRQ_MASK_HIGH_A_ADDR, ACC_WORD, 3'h0, 16'h0000);
        chk("odd word hit", 32'(o_hit), 32'h0);
        acc(1'b0, 16'hFFE3, ACC_BYTE, 3'h0, 16'h0000);
        chk("unmapped read", {16'h0000, o_rdata}, 32'h00000000);
        outs(32'hC3A57E81);
        // Variant images: reserved mask positions written as ones, reserved request flags held at zero
        i_req_flags = 32'h0179FBFB;
        acc(1'b1, IRQ_MASK_LOW_A_ADDR, ACC_WORD, 3'h0, 16'h0444);
        acc(1'b1, IRQ_MASK_LOW_B_ADDR, ACC_WORD, 3'h0, 16'hFE86);
        outs(32'hFE860444);
        // Size code 3 acts as a byte access
        acc(1'b1, IRQ_MASK_LOW_A_ADDR, 2'h3, 3'h0, 16'h00C4);
        acc(1'b1, IRQ_MASK_HIGH_A_ADDR, ACC_BYTE, 3'h0, 16'h0007);
        outs(32'hFE8607C4);
        acc(1'b0, IRQ_MASK_LOW_A_ADDR, ACC_WORD, 3'h0, 16'h0000);
        chk("word read a", {16'h0000, o_rdata}, 32'h000007C4);
        // Second reset in mid-run
        @(negedge i_clk);
        i_resetn = 1'b0;
        @(negedge i_clk);
        i_resetn = 1'b1;
        outs(32'hFFFFFFFF);
        chk("reset rdata", {16'h0000, o_rdata}, 32'h00000000);
        acc(1'b0, IRQ_MASK_HIGH_B_ADDR, ACC_BYTE, 3'h0, 16'h0000);
        chk("reset byte", {16'h0000, o_rdata}, 32'h000000FF);
        conclude();
    end
endmodule // interrupt_mask_flag_bank_test
`default_nettype wire
